// ---- shared/swrc_pkg.sv ----
// Constants and types shared by the sleep, wake and reset controller.
// Assumes a single 50 MHz system clock; all counts are derived from it.
package swrc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  // Internal reset pulse driven onto the reset pin, in nanoseconds.
  localparam int unsigned RST_PULSE_NS = 10_000;
  localparam int unsigned RST_PULSE_CYC =
    (RST_PULSE_NS * CLK_PER_US + 999) / 1000;
  // Clock settling time after leaving deep sleep, in microseconds.
  localparam int unsigned WAKE_DLY_US = 100;
  localparam int unsigned WAKE_CYC_DEF = WAKE_DLY_US * CLK_PER_US;

  // ==========================================================================
  // Structure
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned NUM_GPIO_DEF = 10;
  localparam int unsigned RTC_W_DEF = 16;

  // ==========================================================================
  // Power modes
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_LIGHT,
    ST_DEEP,
    ST_WAKING
  } swrc_state_t;

endpackage

// ---- rtl/swrc_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes each bit is an independent level; no bus coherence is kept.
module swrc_sync
  import swrc_pkg::*;
#(
  parameter int unsigned W = 1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } swrc_sync_t;

  swrc_sync_t s_q;
  swrc_sync_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  // Resets to all ones so an undriven, pulled-up pin does not fake a low.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;

endmodule

// ---- rtl/swrc_top.sv ----
// Sleep, wake and reset controller: power modes, wake sources, reset pin.
// Assumes pins arrive asynchronously; core, radio and serial status come
// from logic on the same clock.
//
// Overview of operation
// - Reset pin active low with internal pull-up.
// - Reset from pin, power-up or watchdog.
// - Internal reset briefly drives reset pin low.
// - Light sleep stops only core, automatically.
// - Deep sleep gates clocks and serial, radio on.
// - Wake pin, GPIO, radio or RTC exit deep.
// - Wake pin high keeps device awake.
// - Clock settling delay before ready after deep.
// - Wake function on one GPIO, others interrupt.
// - GPIO interrupt wakes, then sleep resumes after handler.
// - RAM retained in every power mode.
// - RTC always runs and can raise wakes.
// - GPIO interrupts share channels by index modulo four.
module swrc_top
  import swrc_pkg::*;
#(
  parameter int unsigned NUM_GPIO = NUM_GPIO_DEF,
  parameter int unsigned RTC_W = RTC_W_DEF,
  parameter int unsigned WAKE_CYC = WAKE_CYC_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic rst_pin_pu,
  input wire logic wdt_expire,
  input wire logic [NUM_GPIO-1:0] gpio_i,
  input wire logic [NUM_GPIO-1:0] gpio_irq_en,
  input wire logic wake_en,
  input wire logic [((NUM_GPIO > 1) ? $clog2(NUM_GPIO) : 1)-1:0] wake_sel,
  input wire logic rtc_clk_i,
  input wire logic [RTC_W-1:0] rtc_alarm,
  input wire logic rtc_alarm_en,
  input wire logic rtc_ack,
  input wire logic [NUM_CHAN-1:0] irq_ack,
  input wire logic sleep_en,
  input wire logic cpu_idle,
  input wire logic uart_busy,
  input wire logic radio_active,
  output logic sys_rst,
  output logic core_run,
  output logic clk_en,
  output logic uart_en,
  output logic flow_rdy,
  output logic radio_on,
  output logic ram_keep,
  output logic [NUM_CHAN-1:0] irq_pend,
  output logic rtc_pend,
  output logic [RTC_W-1:0] rtc_count,
  output swrc_state_t mode
);

  // ==========================================================================
  // Widths
  localparam int unsigned WSW = (NUM_GPIO > 1) ? $clog2(NUM_GPIO) : 1;
  localparam int unsigned CW = $clog2(WAKE_CYC + 1);
  localparam int unsigned PW = $clog2(RST_PULSE_CYC + 1);

  // ==========================================================================
  // State
  typedef struct packed {
    swrc_state_t st;
    logic [PW-1:0] pulse;
    logic [CW-1:0] wcnt;
    logic [RTC_W-1:0] rtc;
    logic rtc_prev;
    logic [NUM_GPIO-1:0] gpio_prev;
    logic [NUM_CHAN-1:0] pend;
    logic rtc_pend;
    logic sys_rst;
    logic pin_o;
    logic pin_oe;
    logic pull_up;
    logic core_run;
    logic clk_en;
    logic uart_en;
    logic flow_rdy;
    logic radio_on;
    logic ram_keep;
  } swrc_regs_t;

  swrc_regs_t s_q;
  swrc_regs_t s_d;

  // ==========================================================================
  // Pin synchronisation
  logic [NUM_GPIO+1:0] sync_q;
  logic pin_s;
  logic rtc_s;
  logic [NUM_GPIO-1:0] g_s;

  swrc_sync #(
    .W(NUM_GPIO + 2)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({rst_pin_i, rtc_clk_i, gpio_i}),
    .q(sync_q)
  );

  assign pin_s = sync_q[NUM_GPIO+1];
  assign rtc_s = sync_q[NUM_GPIO];
  assign g_s = sync_q[NUM_GPIO-1:0];

  // ==========================================================================
  // Wake pin selection and interrupt channel sharing
  function automatic logic [NUM_GPIO-1:0] chan_mask(input int unsigned c);
    logic [NUM_GPIO-1:0] m;
    m = '0;
    for (int unsigned i = 0; i < NUM_GPIO; i++)
    begin
      m[i] = ((i % NUM_CHAN) == c);
    end
    return m;
  endfunction

  logic [NUM_GPIO-1:0] wake_oh;
  logic [NUM_GPIO-1:0] pin_evt;
  logic [NUM_CHAN-1:0] chan_evt;
  logic wake_lvl;

  for (genvar i = 0; i < NUM_GPIO; i++)
  begin : gen_pin
    // Only the one selected pin carries the wake function.
    assign wake_oh[i] = wake_en && (wake_sel == WSW'(i));
    assign pin_evt[i] = g_s[i] && !s_q.gpio_prev[i] && gpio_irq_en[i] &&
                        !wake_oh[i];
  end

  for (genvar c = 0; c < NUM_CHAN; c++)
  begin : gen_chan
    // Pins with equal index modulo four fold onto one channel.
    assign chan_evt[c] = |(pin_evt & chan_mask(c));
  end

  assign wake_lvl = |(g_s & wake_oh);

  // ==========================================================================
  // Next state
  logic in_rst;
  logic irq_any;
  logic busy;
  logic rtc_edge;
  logic rtc_evt;

  always_comb
  begin
    s_d = s_q;
    in_rst = 1'b0;
    irq_any = 1'b0;
    busy = 1'b0;
    rtc_edge = rtc_s && !s_q.rtc_prev;
    rtc_evt = 1'b0;
    s_d.gpio_prev = g_s;
    s_d.rtc_prev = rtc_s;
    s_d.pin_o = 1'b0;
    s_d.pull_up = 1'b1;
    // The counter ignores power modes and reset pulses on purpose.
    if (rtc_edge)
    begin
      s_d.rtc = s_q.rtc + RTC_W'(1);
      rtc_evt = rtc_alarm_en && (s_d.rtc == rtc_alarm);
    end
    // A new event wins over an acknowledge in the same cycle.
    s_d.pend = (s_q.pend & ~irq_ack) | chan_evt;
    s_d.rtc_pend = (s_q.rtc_pend && !rtc_ack) || rtc_evt;
    if (wdt_expire)
    begin
      s_d.pulse = PW'(RST_PULSE_CYC);
    end
    else if (s_q.pulse != '0)
    begin
      s_d.pulse = s_q.pulse - PW'(1);
    end
    s_d.pin_oe = (s_d.pulse != '0);
    in_rst = !pin_s || wdt_expire || s_d.pulse != '0;
    irq_any = (|s_d.pend) || s_d.rtc_pend;
    busy = wake_lvl || irq_any || uart_busy;
    if (in_rst)
    begin
      s_d.sys_rst = 1'b1;
      s_d.st = ST_ACTIVE;
      s_d.wcnt = '0;
      s_d.pend = '0;
      s_d.rtc_pend = 1'b0;
    end
    else
    begin
      s_d.sys_rst = 1'b0;
      unique case (s_q.st)
        ST_ACTIVE:
        begin
          // A held wake pin blocks both sleep modes.
          if (cpu_idle && !busy)
          begin
            if (sleep_en && !radio_active)
            begin
              s_d.st = ST_DEEP;
            end
            else
            begin
              s_d.st = ST_LIGHT;
            end
          end
        end
        ST_LIGHT:
        begin
          if (!cpu_idle || busy || radio_active)
          begin
            s_d.st = ST_ACTIVE;
          end
        end
        ST_DEEP:
        begin
          if (wake_lvl || irq_any || radio_active)
          begin
            s_d.st = ST_WAKING;
            s_d.wcnt = CW'(WAKE_CYC);
          end
        end
        ST_WAKING:
        begin
          if (s_q.wcnt <= CW'(1))
          begin
            s_d.st = ST_ACTIVE;
            s_d.wcnt = '0;
          end
          else
          begin
            s_d.wcnt = s_q.wcnt - CW'(1);
          end
        end
      endcase
    end
    // Outputs follow the next mode so they line up with the state register.
    s_d.core_run = (s_d.st == ST_ACTIVE);
    s_d.clk_en = (s_d.st != ST_DEEP);
    s_d.uart_en = (s_d.st == ST_ACTIVE) || (s_d.st == ST_LIGHT);
    // Flow control is the host's only sign that waking has finished.
    s_d.flow_rdy = s_d.uart_en && !s_d.sys_rst;
    s_d.radio_on = 1'b1;
    s_d.ram_keep = 1'b1;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '{st: ST_ACTIVE, pulse: '0, wcnt: '0, rtc: '0, rtc_prev: 1'b1,
               gpio_prev: '1, pend: '0, rtc_pend: 1'b0, sys_rst: 1'b1,
               pin_o: 1'b0, pin_oe: 1'b0, pull_up: 1'b1, core_run: 1'b0,
               clk_en: 1'b1, uart_en: 1'b0, flow_rdy: 1'b0,
               radio_on: 1'b1, ram_keep: 1'b1};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rst_pin_o = s_q.pin_o;
  assign rst_pin_oe = s_q.pin_oe;
  assign rst_pin_pu = s_q.pull_up;
  assign sys_rst = s_q.sys_rst;
  assign core_run = s_q.core_run;
  assign clk_en = s_q.clk_en;
  assign uart_en = s_q.uart_en;
  assign flow_rdy = s_q.flow_rdy;
  assign radio_on = s_q.radio_on;
  assign ram_keep = s_q.ram_keep;
  assign irq_pend = s_q.pend;
  assign rtc_pend = s_q.rtc_pend;
  assign rtc_count = s_q.rtc;
  assign mode = s_q.st;

  // ==========================================================================
  // Checks
  pin_low_reset_a: assert property (
    @(posedge clk) disable iff (rst)
    !pin_s |=> sys_rst && !flow_rdy)
    else $error("reset pin low did not hold reset");

  wdt_reset_a: assert property (
    @(posedge clk) disable iff (rst)
    wdt_expire |=> sys_rst && rst_pin_oe && !rst_pin_o)
    else $error("watchdog expiry did not reset and drive pin");

  pulse_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(rst_pin_oe) |-> (rst_pin_oe && sys_rst)[*8])
    else $error("internal reset pulse too short");

  light_run_a: assert property (
    @(posedge clk) disable iff (rst)
    mode == ST_LIGHT |-> clk_en && uart_en && flow_rdy && !core_run)
    else $error("light sleep stopped more than the core");

  deep_off_a: assert property (
    @(posedge clk) disable iff (rst)
    mode == ST_DEEP |-> !clk_en && !uart_en && !flow_rdy && radio_on)
    else $error("deep sleep gating wrong");

  deep_wake_a: assert property (
    @(posedge clk) disable iff (rst)
    (mode == ST_DEEP && radio_active && !in_rst) |=> mode == ST_WAKING)
    else $error("radio activity did not leave deep sleep");

  wake_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    (mode == ST_ACTIVE && wake_lvl) |=> mode == ST_ACTIVE)
    else $error("sleep entered while wake pin held");

  wake_delay_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(mode == ST_WAKING) |-> s_q.wcnt == CW'(WAKE_CYC) && !flow_rdy)
    else $error("wake delay not loaded");

  deep_entry_a: assert property (
    @(posedge clk) disable iff (rst)
    (mode != ST_DEEP ##1 mode == ST_DEEP) |->
      $past(sleep_en) && !$past(wake_lvl) && !$past(uart_busy))
    else $error("deep sleep entered while not allowed");

  ram_keep_a: assert property (
    @(posedge clk) disable iff (rst)
    ram_keep && radio_on)
    else $error("retention or radio power dropped");

endmodule

// ---- sim/swrc_host.sv ----
// Model of the external host controller: wake pin and reset pull.
// Assumes the bench resolves the reset wire from every driver.
module swrc_host
(
  input wire logic clk,
  input wire logic wake_req,
  input wire logic rst_req,
  input wire logic flow_rdy,
  output logic wake_pin = 1'h0,
  output logic rst_pull,
  output logic rdy_seen = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // The host can only pull the reset line low, never drive it high.
  assign rst_pull = rst_req;
  // Wake stays up for the whole transfer; flow ready is the only sign.
  always_ff @(posedge clk)
  begin
    wake_pin <= wake_req;
    rdy_seen <= wake_req & (rdy_seen | (wake_pin & flow_rdy));
  end
endmodule

// ---- sim/swrc_top_tb_top.sv ----
// Self-checking bench for the sleep, wake and reset controller.
// Assumes the host model in swrc_host and a 50 MHz clock.
module swrc_top_tb_top
  import swrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WK = 16;
  logic clk = 0, rst = 1, wdt = 0, rtc_clk = 0, rtc_en = 0, rtc_ack = 0;
  logic sleep_en = 0, idle = 0, busy = 0, radio = 0;
  logic wake_req = 0, rst_req = 0;
  logic wk_en = 1;
  logic [9:0] irq_en = 10'h3ff;
  logic [9:0] gpio = 10'h0;
  logic [3:0] irq_ack = 4'h0;
  logic rp_o, rp_oe, rp_pu, rst_wire, wake_pin, pull, sys_rst;
  logic core, ce, ue, fr, ron, rk, rtc_pend, rdy_seen;
  logic [3:0] pend, rtc_cnt;
  swrc_state_t mode;
  int err_count = 0;
  int comparisons = 0;
  int n;
  // Row: idle, sleep enable, radio, busy, mode, core/clk/uart/flow.
  logic [9:0] rows [4] = '{10'h320, 10'h217, 10'h34f, 10'h10f};

  always #10 clk = ~clk;
  // The slow crystal runs free at 32 kHz whenever power is present.
  always #15625 rtc_clk = ~rtc_clk;
  assign rst_wire = ((rp_oe && !rp_o) || pull) ? 1'h0 :
    (rp_pu ? 1'h1 : 1'hz);

  swrc_host swrc_host_inst (.clk(clk), .wake_req(wake_req),
    .rst_req(rst_req), .flow_rdy(fr), .wake_pin(wake_pin),
    .rst_pull(pull), .rdy_seen(rdy_seen));

  swrc_top #(.NUM_GPIO(10), .RTC_W(4), .WAKE_CYC(WK)) swrc_top_inst (
    .clk(clk), .rst(rst), .rst_pin_i(rst_wire), .rst_pin_o(rp_o),
    .rst_pin_oe(rp_oe), .rst_pin_pu(rp_pu), .wdt_expire(wdt),
    .gpio_i({gpio[9:1], wake_pin}), .gpio_irq_en(irq_en),
    .wake_en(wk_en), .wake_sel(4'h0), .rtc_clk_i(rtc_clk),
    .rtc_alarm(4'hf), .rtc_alarm_en(rtc_en), .rtc_ack(rtc_ack),
    .irq_ack(irq_ack), .sleep_en(sleep_en), .cpu_idle(idle),
    .uart_busy(busy), .radio_active(radio), .sys_rst(sys_rst),
    .core_run(core), .clk_en(ce), .uart_en(ue), .flow_rdy(fr),
    .radio_on(ron), .ram_keep(rk), .irq_pend(pend),
    .rtc_pend(rtc_pend), .rtc_count(rtc_cnt), .mode(mode));

  // ==========================================================================
  // Helpers
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  task automatic finish_test();
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A wait that runs out is a failure and ends the run at once.
  task automatic wait_mode(swrc_state_t m, int lim);
    int i;
    i = 0;
    while (mode !== m && i < lim)
    begin
      step(1);
      i++;
    end
    if (mode !== m)
    begin
      chk("mode wait", 16'(mode), 16'(m));
      finish_test();
    end
  endtask

  // ==========================================================================
  // Sequence
  initial
  begin
    step(4);
    chk("reset state", 16'({sys_rst, rp_oe, rp_pu}), 16'h5);
    rst = 0;
    step(2);
    chk("ready", 16'({sys_rst, fr}), 16'h1);
    foreach (rows[i])
    begin
      {idle, sleep_en, radio, busy} = rows[i][9:6];
      step(3);
      chk("mode", 16'(mode), 16'(rows[i][5:4]));
      chk("gates", 16'({core, ce, ue, fr}), 16'(rows[i][3:0]));
      chk("keep", 16'({ron, rk}), 16'h3);
      {idle, radio, busy} = 3'h2;
      step(1);
      radio = 0;
      wait_mode(ST_ACTIVE, 40);
    end
    rst_req = 1;
    step(4);
    chk("pin reset", 16'({sys_rst, rp_oe}), 16'h2);
    rst_req = 0;
    step(5);
    chk("pin release", 16'(sys_rst), 16'h0);
    wdt = 1;
    step(1);
    wdt = 0;
    chk("wdt", 16'({sys_rst, rp_oe, rst_wire}), 16'h6);
    n = 0;
    while (rp_oe === 1'h1 && n < 600)
    begin
      step(1);
      n++;
    end
    chk("pulse", 16'(n), 16'(RST_PULSE_CYC));
    step(6);
    chk("wdt release", 16'({sys_rst, fr}), 16'h1);
    {idle, sleep_en} = 2'h3;
    step(3);
    chk("deep", 16'(mode), 16'(ST_DEEP));
    wake_req = 1;
    wait_mode(ST_WAKING, 8);
    n = 0;
    while (fr !== 1'h1 && n < 100)
    begin
      step(1);
      n++;
    end
    chk("wake delay", 16'(n >= WK && n <= WK + 2), 16'h1);
    step(20);
    chk("held awake", 16'({mode, rdy_seen, pend}), 16'h10);
    wake_req = 0;
    step(8);
    chk("back deep", 16'(mode), 16'(ST_DEEP));
    for (int i = 1; i < 10; i++)
    begin
      gpio[i] = 1;
      step(6);
      chk("channel", 16'(pend), 16'(1 << (i % 4)));
      chk("irq wake", 16'(mode === ST_DEEP), 16'h0);
      irq_ack = 4'(1 << (i % 4));
      gpio[i] = 0;
      step(1);
      irq_ack = 4'h0;
      wait_mode(ST_DEEP, 40);
    end
    // A masked pin must neither set a channel nor wake the device.
    irq_en[2] = 0;
    gpio[2] = 1;
    step(6);
    chk("masked", 16'({mode, pend}), 16'h20);
    gpio[2] = 0;
    step(1);
    irq_en = 10'h3ff;
    // Without the wake function the pin is a plain channel 0 interrupt.
    wk_en = 0;
    wake_req = 1;
    step(7);
    chk("plain pin", 16'(pend), 16'h1);
    irq_ack = 4'h1;
    step(1);
    irq_ack = 4'h0;
    wait_mode(ST_DEEP, 40);
    wake_req = 0;
    step(4);
    wk_en = 1;
    rtc_en = 1;
    n = 0;
    while (rtc_pend !== 1'h1 && n < 30000)
    begin
      step(1);
      n++;
    end
    chk("alarm", 16'({rtc_pend, rtc_cnt}), 16'h1f);
    wait_mode(ST_WAKING, 4);
    rtc_ack = 1;
    step(1);
    rtc_ack = 0;
    wait_mode(ST_DEEP, 40);
    finish_test();
  end
endmodule
